// [rtl/ast_pkg.sv]
package ast_pkg;

    // Register byte offsets
    localparam logic [7:0] AST_OFF_STATUS = 8'h00;
    localparam logic [7:0] AST_OFF_DATA   = 8'h04;
    localparam logic [7:0] AST_OFF_CTRL1  = 8'h08;
    localparam logic [7:0] AST_OFF_CTRL2  = 8'h0C;
    localparam logic [7:0] AST_OFF_BAUD   = 8'h10;

    // Decoded register index
    localparam logic [2:0] AST_IDX_STATUS = 3'h0;
    localparam logic [2:0] AST_IDX_DATA   = 3'h1;
    localparam logic [2:0] AST_IDX_CTRL1  = 3'h2;
    localparam logic [2:0] AST_IDX_CTRL2  = 3'h3;
    localparam logic [2:0] AST_IDX_BAUD   = 3'h4;
    localparam logic [2:0] AST_IDX_NONE   = 3'h7;

    // Status bits
    localparam int AST_ST_TXE  = 7;
    localparam int AST_ST_TXD  = 6;
    localparam int AST_ST_RXF  = 5;
    localparam int AST_ST_OVR  = 3;
    localparam int AST_ST_NSE  = 2;
    localparam int AST_ST_FRM  = 1;
    // Control one bits
    localparam int AST_C1_RX9  = 7;
    localparam int AST_C1_TX9  = 6;
    localparam int AST_C1_WL9  = 4;
    localparam logic [7:0] AST_C1_WMASK = 8'h50;
    // Control two bits
    localparam int AST_C2_TIE  = 7;
    localparam int AST_C2_TX_DONE_IRQ_EN = 6;
    localparam int AST_C2_RIE  = 5;
    localparam int AST_C2_TE   = 3;
    localparam int AST_C2_RE   = 2;
    localparam int AST_C2_SBK  = 0;
    // Baud select fields: coarse [7:6], tx power [5:3], rx power [2:0]
    localparam int AST_BD_CRS  = 6;
    localparam int AST_BD_TXP  = 3;
    localparam int AST_BD_RXP  = 0;

    // Coarse divider values
    localparam logic [10:0] AST_CRS_1  = 11'h001;
    localparam logic [10:0] AST_CRS_3  = 11'h003;
    localparam logic [10:0] AST_CRS_4  = 11'h004;
    localparam logic [10:0] AST_CRS_13 = 11'h00D;

    // Bit timing in sixteenth-bit ticks, frame lengths in bits
    localparam logic [3:0] AST_SUB_LAST  = 4'hF;
    localparam logic [3:0] AST_SMP_FIRST = 4'h7;
    localparam logic [3:0] AST_SMP_LAST  = 4'h9;
    localparam logic [3:0] AST_FLEN8     = 4'hA;
    localparam logic [3:0] AST_FLEN9     = 4'hB;

    localparam logic [1:0] AST_RESP_OKAY   = 2'h0;
    localparam logic [1:0] AST_RESP_SLVERR = 2'h2;
    localparam logic [7:0] AST_STATUS_RST  = 8'hC0;

    typedef enum logic [3:0] {
        AST_TX_OFF   = 4'h1,
        AST_TX_IDLE  = 4'h2,
        AST_TX_FRAME = 4'h4,
        AST_TX_MARK  = 4'h8
    } ast_tx_st_t;

    typedef enum logic [2:0] {
        AST_RX_OFF  = 3'h1,
        AST_RX_HUNT = 3'h2,
        AST_RX_BIT  = 3'h4
    } ast_rx_st_t;

endpackage

// [rtl/ast_serial.sv]
// Contract
// - Idle line high while enabled; pin released when both directions off.
// - Frame is start bit, 8 or 9 data bits LSB first, stop bit.
// - Start bit driven low, stop bit driven high, whole bit each.
// - Nine-bit mode sends tx_ninth_bit as the ninth, most significant bit.
// - Nine-bit mode stores received top bit in rx_ninth_bit.
// - Idle character is one whole frame of ones.
// - Break frames of zeros while send_break_bit set, then one mark bit.
// - Enabling transmitter sends idle frame first; re-enable drops buffered data (a byte buffered while the sender is off goes out ahead of the idle frame).
// - Buffer empty flag sets when buffer moves to shifter; may interrupt.
// - Write while sending waits in hold buffer until the frame ends.
// - Write while idle starts sending at once and sets buffer empty.
// - Transmit done flag sets after stop bit; may interrupt.
// - Status read then data write clears both transmit flags.
// - Receive enable starts hunting for a start bit.
// - Completed character moves to rx buffer, sets full flag, may interrupt.
// - Framing, noise and overrun flags set on their conditions.
// - Status read then data read clears full flag; read returns buffer.
// - Separate transmit and receive baud generators from core clock.
// - Receive line is oversampled to reject noise.
// - Bit valid when samples 8, 9, 10 agree, else noise flag.
// - Overrun keeps old buffer, sets overrun flag, shifter overwritten.
// - Bad stop bit or break sets framing flag with the full flag.
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ast_serial
    import ast_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        rstn_i,
    // AXI4-Lite write
    input  wire logic        s_axil_awvalid_i,
    output logic             s_axil_awready_o,
    input  wire logic [7:0]  s_axil_awaddr_i,
    input  wire logic        s_axil_wvalid_i,
    output logic             s_axil_wready_o,
    input  wire logic [31:0] s_axil_wdata_i,
    input  wire logic [3:0]  s_axil_wstrb_i,
    output logic             s_axil_bvalid_o,
    input  wire logic        s_axil_bready_i,
    output logic [1:0]       s_axil_bresp_o,
    // AXI4-Lite read
    input  wire logic        s_axil_arvalid_i,
    output logic             s_axil_arready_o,
    input  wire logic [7:0]  s_axil_araddr_i,
    output logic             s_axil_rvalid_o,
    input  wire logic        s_axil_rready_i,
    output logic [31:0]      s_axil_rdata_o,
    output logic [1:0]       s_axil_rresp_o,
    // Serial pins
    output logic             tx_line_o,
    output logic             tx_line_oe_o,
    input  wire logic        rx_line_in_i,
    // Processor interrupt mask and request
    input  wire logic        cpu_irq_mask_i,
    output logic             irq_o
);

    typedef struct packed {
        logic             aw_full;
        logic [7:0]       aw_addr;
        logic             w_full;
        logic [7:0]       w_data;
        logic             w_lane0;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             rvalid;
        logic [7:0]       rdata;
        logic [1:0]       rresp;
        logic [7:0]       ctrl1;
        logic [7:0]       ctrl2;
        logic [7:0]       baud;
        logic [7:0]       status;
        logic             seen;
        logic             noise_pend;
        logic [7:0]       tx_buf;
        logic             tx_buf_full;
        ast_tx_st_t       tx_st;
        logic [10:0]      tx_pre;
        logic [3:0]       tx_sub;
        logic [3:0]       tx_bit;
        logic [10:0]      tx_shift;
        logic             tx_brk;
        logic             te_prev;
        logic             idle_req;
        logic [8:0]       rx_buf;
        ast_rx_st_t       rx_st;
        logic [10:0]      rx_pre;
        logic [3:0]       rx_sub;
        logic [3:0]       rx_bit;
        logic [8:0]       rx_shift;
        logic [2:0]       vote;
        logic             rx_prev;
    } ast_state_t;

    ast_state_t q;
    ast_state_t d;

    // Address to register index, unmapped gives the none index
    function automatic logic [2:0] ast_decode(input logic [7:0] a);
        case (a)
            AST_OFF_STATUS: ast_decode = AST_IDX_STATUS;
            AST_OFF_DATA:   ast_decode = AST_IDX_DATA;
            AST_OFF_CTRL1:  ast_decode = AST_IDX_CTRL1;
            AST_OFF_CTRL2:  ast_decode = AST_IDX_CTRL2;
            AST_OFF_BAUD:   ast_decode = AST_IDX_BAUD;
            default:        ast_decode = AST_IDX_NONE;
        endcase
    endfunction

    // Prescaler terminal count: coarse times power of two, minus one
    function automatic logic [10:0] ast_div(input logic [1:0] crs,
                                            input logic [2:0] pw);
        logic [10:0] base;
        case (crs)
            2'h0:    base = AST_CRS_1;
            2'h1:    base = AST_CRS_3;
            2'h2:    base = AST_CRS_4;
            default: base = AST_CRS_13;
        endcase
        ast_div = (base << pw) - 11'h001;
    endfunction

    logic        wr_go;
    logic        rd_go;
    logic [2:0]  wr_idx;
    logic [2:0]  rd_idx;
    logic        te;
    logic        re;
    logic        word9;
    logic [3:0]  flen;
    logic        tx_tick;
    logic        tx_bit_end;
    logic        tx_frame_end;
    logic        rx_tick;
    logic        rx_decide;
    logic [2:0]  vote_n;
    logic        rx_val;
    logic        rx_dis;
    logic        rx_done;
    logic        rx_over;
    logic [8:0]  rx_word;

    // Handshake outputs straight from state
    assign s_axil_awready_o = ~q.aw_full & ~q.bvalid;
    assign s_axil_wready_o  = ~q.w_full & ~q.bvalid;
    assign s_axil_arready_o = ~q.rvalid;
    assign s_axil_bvalid_o  = q.bvalid;
    assign s_axil_bresp_o   = q.bresp;
    assign s_axil_rvalid_o  = q.rvalid;
    assign s_axil_rdata_o   = {24'h000000, q.rdata};
    assign s_axil_rresp_o   = q.rresp;

    // Pin ownership and level
    assign tx_line_oe_o = q.ctrl2[AST_C2_TE] | q.ctrl2[AST_C2_RE];
    assign tx_line_o    = (q.tx_st == AST_TX_FRAME) ? q.tx_shift[0] : 1'b1;

    // Interrupt request gated by processor mask
    assign irq_o = ~cpu_irq_mask_i &
        ((q.status[AST_ST_TXE] & q.ctrl2[AST_C2_TIE]) |
         (q.status[AST_ST_TXD] & q.ctrl2[AST_C2_TX_DONE_IRQ_EN]) |
         (q.status[AST_ST_RXF] & q.ctrl2[AST_C2_RIE]));

    // Whole next-state function; later sets override earlier clears
    always_comb
    begin
        d        = q;
        wr_go    = q.aw_full & q.w_full & ~q.bvalid;
        rd_go    = s_axil_arvalid_i & ~q.rvalid;
        wr_idx   = ast_decode(q.aw_addr);
        rd_idx   = ast_decode(s_axil_araddr_i);
        te       = q.ctrl2[AST_C2_TE];
        re       = q.ctrl2[AST_C2_RE];
        word9    = q.ctrl1[AST_C1_WL9];
        flen     = word9 ? AST_FLEN9 : AST_FLEN8;

        // Bus capture and release
        if (s_axil_awvalid_i & s_axil_awready_o)
        begin
            d.aw_full = 1'b1;
            d.aw_addr = s_axil_awaddr_i;
        end
        if (s_axil_wvalid_i & s_axil_wready_o)
        begin
            d.w_full  = 1'b1;
            d.w_data  = s_axil_wdata_i[7:0];
            d.w_lane0 = s_axil_wstrb_i[0];
        end
        if (q.bvalid & s_axil_bready_i)
            d.bvalid = 1'b0;
        if (q.rvalid & s_axil_rready_i)
            d.rvalid = 1'b0;

        // Register writes; byte lane 0 carries every field
        if (wr_go)
        begin
            d.aw_full = 1'b0;
            d.w_full  = 1'b0;
            d.bvalid  = 1'b1;
            d.bresp   = (wr_idx == AST_IDX_NONE) ? AST_RESP_SLVERR
                                                 : AST_RESP_OKAY;
            if (q.w_lane0)
            begin
                case (wr_idx)
                    AST_IDX_DATA:
                    begin
                        d.tx_buf      = q.w_data;
                        d.tx_buf_full = 1'b1;
                        if (q.seen)
                        begin
                            d.status[AST_ST_TXE] = 1'b0;
                            d.status[AST_ST_TXD] = 1'b0;
                        end
                        d.seen = 1'b0;
                    end
                    AST_IDX_CTRL1:
                        d.ctrl1 = (q.ctrl1 & ~AST_C1_WMASK) |
                                  (q.w_data & AST_C1_WMASK);
                    AST_IDX_CTRL2: d.ctrl2 = q.w_data;
                    AST_IDX_BAUD:  d.baud  = q.w_data;
                    default: ;
                endcase
            end
        end

        // Register reads and the read side of the clearing sequences
        if (rd_go)
        begin
            d.rvalid = 1'b1;
            d.rresp  = (rd_idx == AST_IDX_NONE) ? AST_RESP_SLVERR
                                                : AST_RESP_OKAY;
            case (rd_idx)
                AST_IDX_STATUS:
                begin
                    d.rdata = q.status;
                    d.seen  = 1'b1;
                end
                AST_IDX_DATA:
                begin
                    d.rdata = q.rx_buf[7:0];
                    if (q.seen)
                    begin
                        d.status[AST_ST_RXF] = 1'b0;
                        d.status[AST_ST_OVR] = 1'b0;
                        d.status[AST_ST_NSE] = 1'b0;
                        d.status[AST_ST_FRM] = 1'b0;
                    end
                    d.seen = 1'b0;
                end
                AST_IDX_CTRL1:
                    d.rdata = {q.rx_buf[8], q.ctrl1[6:0]};
                AST_IDX_CTRL2: d.rdata = q.ctrl2;
                AST_IDX_BAUD:  d.rdata = q.baud;
                default:       d.rdata = 8'h00;
            endcase
        end

        // Transmit baud prescaler, runs only while sending a frame or the mark bit
        tx_tick = q.tx_pre == ast_div(q.baud[AST_BD_CRS +: 2],
                                      q.baud[AST_BD_TXP +: 3]);
        tx_bit_end   = 1'b0;
        tx_frame_end = 1'b0;
        if (q.tx_st == AST_TX_FRAME || q.tx_st == AST_TX_MARK)
        begin
            d.tx_pre = tx_tick ? 11'h000 : q.tx_pre + 11'h001;
            if (tx_tick)
                d.tx_sub = q.tx_sub + 4'h1;
            tx_bit_end   = tx_tick & (q.tx_sub == AST_SUB_LAST);
            tx_frame_end = tx_bit_end & ((q.tx_st == AST_TX_MARK) |
                           (q.tx_bit == flen - 4'h1));
        end
        else
        begin
            d.tx_pre = 11'h000;
            d.tx_sub = 4'h0;
        end

        // Shift out LSB first, ones fill behind
        if (tx_bit_end && q.tx_st == AST_TX_FRAME)
        begin
            d.tx_shift = {1'b1, q.tx_shift[10:1]};
            d.tx_bit   = q.tx_bit + 4'h1;
        end
        if (tx_frame_end && q.tx_st == AST_TX_FRAME)
            d.status[AST_ST_TXD] = 1'b1;

        // Launch the next frame at a boundary or from rest
        if (tx_frame_end || q.tx_st == AST_TX_IDLE || q.tx_st == AST_TX_OFF)
        begin
            d.tx_st  = te ? AST_TX_IDLE : AST_TX_OFF;
            d.tx_bit = 4'h0;
            if (te)
            begin
                if (q.ctrl2[AST_C2_SBK])
                begin
                    d.tx_shift = 11'h000;
                    d.tx_brk   = 1'b1;
                    d.tx_st    = AST_TX_FRAME;
                end
                else if (q.tx_brk)
                begin
                    d.tx_brk = 1'b0;
                    d.tx_st  = AST_TX_MARK;
                end
                else if (q.idle_req)
                begin
                    d.tx_shift = 11'h7FF;
                    d.idle_req = 1'b0;
                    d.tx_st    = AST_TX_FRAME;
                end
                else if (q.tx_buf_full)
                begin
                    // Stop high, start low around the data
                    d.tx_shift = word9 ?
                        {1'b1, q.ctrl1[AST_C1_TX9], q.tx_buf, 1'b0} :
                        {2'b11, q.tx_buf, 1'b0};
                    d.tx_buf_full        = 1'b0;
                    d.status[AST_ST_TXE] = 1'b1;
                    d.tx_st              = AST_TX_FRAME;
                end
            end
        end

        // Re-enable queues an idle frame and drops buffered data that the launch above did not take this cycle
        d.te_prev = te;
        if (te & ~q.te_prev)
        begin
            d.idle_req    = 1'b1;
            d.tx_buf_full = 1'b0;
        end

        // Receive prescaler and majority vote of samples 8, 9, 10
        rx_tick   = q.rx_pre == ast_div(q.baud[AST_BD_CRS +: 2],
                                        q.baud[AST_BD_RXP +: 3]);
        vote_n    = {q.vote[1:0], rx_line_in_i};
        rx_val    = (vote_n[0] & vote_n[1]) | (vote_n[1] & vote_n[2]) |
                    (vote_n[0] & vote_n[2]);
        rx_dis    = ~(&vote_n) & (|vote_n);
        rx_decide = 1'b0;
        rx_done   = 1'b0;
        rx_over   = 1'b0;
        rx_word   = word9 ? q.rx_shift : {1'b0, q.rx_shift[8:1]};
        d.rx_prev = rx_line_in_i;

        case (q.rx_st)
            AST_RX_OFF:
                if (re)
                    d.rx_st = AST_RX_HUNT;
            AST_RX_HUNT:
            begin
                d.rx_pre = 11'h000;
                d.rx_sub = 4'h0;
                if (q.rx_prev & ~rx_line_in_i)
                begin
                    d.rx_st  = AST_RX_BIT;
                    d.rx_bit = 4'h0;
                end
            end
            AST_RX_BIT:
            begin
                d.rx_pre = rx_tick ? 11'h000 : q.rx_pre + 11'h001;
                if (rx_tick)
                begin
                    d.rx_sub = q.rx_sub + 4'h1;
                    if (q.rx_sub >= AST_SMP_FIRST && q.rx_sub <= AST_SMP_LAST)
                        d.vote = vote_n;
                    if (q.rx_sub == AST_SUB_LAST)
                        d.rx_bit = q.rx_bit + 4'h1;
                end
                rx_decide = rx_tick & (q.rx_sub == AST_SMP_LAST);
                if (rx_decide)
                begin
                    if (rx_dis)
                        d.noise_pend = 1'b1;
                    if (q.rx_bit == 4'h0)
                    begin
                        // False start: drop frame, keep noise for next
                        if (rx_val)
                        begin
                            d.noise_pend = 1'b1;
                            d.rx_st      = AST_RX_HUNT;
                        end
                    end
                    else if (q.rx_bit < flen - 4'h1)
                        d.rx_shift = {rx_val, q.rx_shift[8:1]};
                    else
                    begin
                        rx_done = 1'b1;
                        d.rx_st = AST_RX_HUNT;
                    end
                end
            end
            default: d.rx_st = AST_RX_OFF;
        endcase
        if (!re)
            d.rx_st = AST_RX_OFF;

        // Character complete: transfer or overrun
        if (rx_done)
        begin
            if (d.status[AST_ST_RXF])
            begin
                rx_over              = 1'b1;
                d.status[AST_ST_OVR] = 1'b1;
            end
            else
            begin
                d.rx_buf[7:0]        = rx_word[7:0];
                if (word9)
                    d.rx_buf[8]      = rx_word[8];
                d.status[AST_ST_RXF] = 1'b1;
                d.status[AST_ST_NSE] = q.noise_pend | rx_dis;
                d.status[AST_ST_FRM] = ~rx_val;
                d.noise_pend         = 1'b0;
            end
        end
    end

    // Single state register
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            q         <= '0;
            q.status  <= AST_STATUS_RST;
            q.tx_st   <= AST_TX_OFF;
            q.rx_st   <= AST_RX_OFF;
            q.rx_prev <= 1'b1;
        end
        else
            q <= d;
    end

    property p_start_low;
        @(posedge core_clk_i) disable iff (!rstn_i)
        (q.tx_st == AST_TX_FRAME && q.tx_bit == 4'h0 && !q.tx_brk &&
         !q.tx_shift[1]) |-> !tx_line_o;
    endproperty
    a_start_low: assert property (p_start_low)
        else $error("start bit not low");

    property p_stop_high;
        @(posedge core_clk_i) disable iff (!rstn_i)
        (q.tx_st == AST_TX_FRAME && !q.tx_brk && q.tx_bit == flen - 4'h1)
        |-> tx_line_o;
    endproperty
    a_stop_high: assert property (p_stop_high)
        else $error("stop bit not high");

    property p_done_after_stop;
        @(posedge core_clk_i) disable iff (!rstn_i)
        (tx_frame_end && q.tx_st == AST_TX_FRAME) |=> q.status[AST_ST_TXD];
    endproperty
    a_done_after_stop: assert property (p_done_after_stop)
        else $error("done flag missing after stop bit");

    property p_empty_on_load;
        @(posedge core_clk_i) disable iff (!rstn_i)
        (q.tx_buf_full && te && q.tx_st == AST_TX_IDLE && !q.idle_req &&
         !q.tx_brk && !q.ctrl2[AST_C2_SBK])
        |=> (q.status[AST_ST_TXE] && q.tx_st == AST_TX_FRAME && !q.tx_buf_full);
    endproperty
    a_empty_on_load: assert property (p_empty_on_load)
        else $error("idle write did not start frame");

    property p_tx_clear_seq;
        @(posedge core_clk_i) disable iff (!rstn_i)
        $fell(q.status[AST_ST_TXD]) |->
            $past(wr_go && wr_idx == AST_IDX_DATA && q.seen);
    endproperty
    a_tx_clear_seq: assert property (p_tx_clear_seq)
        else $error("done flag cleared without sequence");

    property p_reenable_drops;
        @(posedge core_clk_i) disable iff (!rstn_i)
        (te && !q.te_prev) |=> (!q.tx_buf_full && q.idle_req) or
                               (q.tx_st == AST_TX_FRAME && q.tx_shift[0]);
    endproperty
    a_reenable_drops: assert property (p_reenable_drops)
        else $error("enable rise kept buffered data");

    property p_rx_full;
        @(posedge core_clk_i) disable iff (!rstn_i)
        (rx_done && !rx_over) |=> (q.status[AST_ST_RXF] &&
                                   q.rx_buf[7:0] == $past(rx_word[7:0]));
    endproperty
    a_rx_full: assert property (p_rx_full)
        else $error("character not transferred");

    property p_overrun;
        @(posedge core_clk_i) disable iff (!rstn_i)
        rx_over |=> (q.status[AST_ST_OVR] && $stable(q.rx_buf));
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("overrun handling wrong");

    property p_noise;
        @(posedge core_clk_i) disable iff (!rstn_i)
        (rx_decide && rx_dis && q.rx_bit != 4'h0 && !rx_done) |=> q.noise_pend;
    endproperty
    a_noise: assert property (p_noise)
        else $error("sample disagreement not noted");

endmodule
`default_nettype wire

// [dv/ast_far_end.sv]
`timescale 1ns/1ps
`default_nettype none
// Far-end equipment, 16 core cycles per bit
module ast_far_end
(
    // Clock and serial lines
    input  wire logic core_clk_i,
    input  wire logic tx_line_i,
    output logic      rx_line_o
);
    // Mark level between frames
    initial rx_line_o = 1'b1;

    // Start, data LSB first, stop; low stp gives a bad stop bit,
    // bit nb gets a one-cycle glitch on its middle sample
    task automatic send(input logic [8:0] w, input int n, input logic stp,
                        input int nb);
        for (int i = -1; i <= n; i++)
        begin
            @(posedge core_clk_i);
            rx_line_o <= (i < 0) ? 1'b0 : (i == n) ? stp : w[i];
            repeat (9) @(posedge core_clk_i);
            if (i == nb)
                rx_line_o <= ~rx_line_o;
            @(posedge core_clk_i);
            if (i == nb)
                rx_line_o <= ~rx_line_o;
            repeat (5) @(posedge core_clk_i);
        end
        @(posedge core_clk_i);
        rx_line_o <= 1'b1;
    endtask

    // Mid-bit sampling from the start edge; t counts the bounded wait
    task automatic grab(output logic [8:0] w, output logic stp,
                        input int n, output int t);
        w = 9'h000;
        t = 0;
        while (tx_line_i !== 1'b0 && t < 3000)
        begin
            @(posedge core_clk_i);
            t++;
        end
        repeat (8) @(posedge core_clk_i);
        for (int i = 0; i < n; i++)
        begin
            repeat (16) @(posedge core_clk_i);
            w[i] = tx_line_i;
        end
        repeat (16) @(posedge core_clk_i);
        stp = tx_line_i;
    endtask
endmodule
`default_nettype wire

// [dv/tb_ast_serial.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_ast_serial;
    import ast_pkg::*;
    // Bench state
    logic        clk = 0, rstn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    logic        awr, wrd, bv, arr, rv, tx, oe, rx, s1, s2, irq, msk = 0;
    logic [7:0]  aw = 0;
    logic [31:0] wd = 0, rd, v;
    logic [1:0]  br, rsp, rr;
    logic [8:0]  w1, w2;
    int          t1, t2, error_cnt = 0, compares = 0;

    // 250 MHz core clock
    always #2 clk = ~clk;

    ast_serial dut (
        .core_clk_i(clk), .rstn_i(rstn), .s_axil_awvalid_i(awv),
        .s_axil_awready_o(awr), .s_axil_awaddr_i(aw), .s_axil_wvalid_i(wv),
        .s_axil_wready_o(wrd), .s_axil_wdata_i(wd), .s_axil_wstrb_i(4'hF),
        .s_axil_bvalid_o(bv), .s_axil_bready_i(bry), .s_axil_bresp_o(br),
        .s_axil_arvalid_i(arv), .s_axil_arready_o(arr),
        .s_axil_araddr_i(aw), .s_axil_rvalid_o(rv), .s_axil_rready_i(rry),
        .s_axil_rdata_o(rd), .s_axil_rresp_o(rsp), .tx_line_o(tx),
        .tx_line_oe_o(oe), .rx_line_in_i(rx), .cpu_irq_mask_i(msk),
        .irq_o(irq));
    ast_far_end far (.core_clk_i(clk), .tx_line_i(tx), .rx_line_o(rx));

    task automatic stop_test();
        if (error_cnt == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    // One bus access; each channel released on its own handshake edge
    task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
        int t;
        @(posedge clk);
        t = 0;
        {awv, wv, bry, arv, rry} <= {we, we, we, !we, !we};
        aw <= a;
        wd <= d;
        do
        begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
            if (arr) arv <= 1'b0;
            t++;
        end
        while (bv !== 1'b1 && rv !== 1'b1 && t < 50);
        {v, rr} = {rd, we ? br : rsp};
        {bry, rry} <= 2'b00;
        if (t >= 50)
        begin
            error_cnt++;
            stop_test();
        end
    endtask

    task automatic rc(input logic [7:0] a, input logic [7:0] m,
                      input logic [7:0] e, input string n);
        xfer(1'b0, a, 0);
        chk(n, {24'h0, e}, v & {24'h0, m});
    endtask

    // Main sequence
    initial
    begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        rc(AST_OFF_STATUS, 8'hFF, 8'hC0, "status");
        rc(8'h40, 8'hFF, 8'h00, "unmapped");
        chk("resp", 32'(AST_RESP_SLVERR), 32'(rr));
        chk("oe", 0, 32'(oe));
        chk("irq", 0, 32'(irq));
        xfer(1'b1, AST_OFF_BAUD, 0);
        chk("resp", 32'(AST_RESP_OKAY), 32'(rr));
        xfer(1'b1, AST_OFF_CTRL2, 32'h0C);
        chk("line", 1, 32'(tx));
        fork
            far.grab(w1, s1, 8, t1);
            xfer(1'b1, AST_OFF_DATA, 32'hA5);
        join
        chk("idle", 1, 32'(t1 > 150 && t1 < 3000));
        chk("word", 32'hA5, 32'(w1));
        chk("stop", 1, 32'(s1));
        // Let that frame end so the next write finds the sender idle
        repeat (10) @(posedge clk);
        rc(AST_OFF_STATUS, 8'hC0, 8'hC0, "txflags");
        fork
            begin
                far.grab(w1, s1, 8, t1);
                far.grab(w2, s2, 8, t2);
            end
            begin
                xfer(1'b1, AST_OFF_DATA, 32'h31);
                rc(AST_OFF_STATUS, 8'hC0, 8'h80, "txflags");
                xfer(1'b1, AST_OFF_DATA, 32'hC6);
            end
        join
        chk("word", 32'h31, 32'(w1));
        chk("word", 32'hC6, 32'(w2));
        repeat (20) @(posedge clk);
        rc(AST_OFF_STATUS, 8'hC0, 8'hC0, "txflags");
        far.send(9'h03C, 8, 1'b1, 15);
        rc(AST_OFF_STATUS, 8'h2E, 8'h20, "rxflags");
        rc(AST_OFF_DATA, 8'hFF, 8'h3C, "rxdata");
        rc(AST_OFF_STATUS, 8'h2E, 8'h00, "rxflags");
        far.send(9'h011, 8, 1'b0, 15);
        far.send(9'h022, 8, 1'b1, 15);
        rc(AST_OFF_STATUS, 8'h2E, 8'h2A, "rxflags");
        rc(AST_OFF_DATA, 8'hFF, 8'h11, "rxdata");
        rc(AST_OFF_STATUS, 8'h2E, 8'h00, "rxflags");
        far.send(9'h0A5, 8, 1'b1, 3);
        rc(AST_OFF_STATUS, 8'h2E, 8'h24, "rxflags");
        rc(AST_OFF_DATA, 8'hFF, 8'hA5, "rxdata");
        xfer(1'b1, AST_OFF_CTRL1, 32'h50);
        fork
            far.grab(w1, s1, 9, t1);
            xfer(1'b1, AST_OFF_DATA, 32'h5A);
        join
        chk("word", 32'h15A, 32'(w1));
        far.send(9'h1C3, 9, 1'b1, 15);
        rc(AST_OFF_CTRL1, 8'h80, 8'h80, "ninth");
        rc(AST_OFF_STATUS, 8'h20, 8'h20, "rxflags");
        xfer(1'b1, AST_OFF_CTRL2, 32'h2C);
        chk("irq", 1, 32'(irq));
        msk <= 1'b1;
        @(posedge clk);
        chk("irq", 0, 32'(irq));
        rc(AST_OFF_DATA, 8'hFF, 8'hC3, "rxdata");
        xfer(1'b1, AST_OFF_CTRL2, 32'h0D);
        repeat (100) @(posedge clk);
        chk("break", 0, 32'(tx));
        xfer(1'b1, AST_OFF_CTRL2, 32'h0C);
        repeat (200) @(posedge clk);
        chk("mark", 1, 32'(tx));
        xfer(1'b1, AST_OFF_CTRL2, 0);
        chk("oe", 0, 32'(oe));
        stop_test();
    end
endmodule
`default_nettype wire
